// ### design/dmab_dma_master.sv
// DMA end: AXI4 master moving packet buffer words to and from memory
// Function
// [R1] Bursts at most sixteen beats, length upper zero
// [R2] Size field follows configured data width; a 128-bit selection gets the 64-bit size
// [R3] Burst type always incrementing
// [R4] IDs and lock outputs held low
// [R5] Non-OKAY response raises error interrupt
// [R6] Narrow write data upper bits zero
// [R7] Write last with final beat
// [R8] Cache and protection fixed by parameters
// [R9] Bus reset asynchronous assert, synchronous release
// [R10] System ties unused read data bits
// [R11] Transmit buffer dual port, bus/transmit clocks
// [R12] Transmit buffer: bus port writes, other reads
// [R13] Receive buffer dual port, receive/bus clocks
// [R14] Receive buffer: receive port writes, bus reads
// [R15] Buffer data 32 or 64 bits wide
// [R16] Buffer word addressed, depth set by width
// [R17] Each domain has own synchronised reset
// [R18] Loopback retimed on inverted transmit clock
// [R19] Width selection is three-bit software setting
// [R20] Valid held with payload until ready
// [R21] Response ready held while transaction outstanding
module dmab_dma_master #(
	parameter logic [3:0] CACHE = dmab_pkg::CACHE_VAL, // R8
	parameter logic [2:0] PROT  = dmab_pkg::PROT_VAL
) (
	dmab_axi_if.master         axi,          // AXI master side
	input  wire logic [2:0]    i_bus_width,  // Width selection
	input  wire logic          i_wr_start,   // Pulse: start mem write
	input  wire logic          i_rd_start,   // Pulse: start mem read
	input  wire logic [31:0]   i_addr,       // Burst start address
	input  wire logic [3:0]    i_len,        // Beats minus one
	input  wire logic [7:0]    i_rx_pb_base, // Rx buffer word address
	input  wire logic [7:0]    i_tx_pb_base, // Tx buffer word address
	input  wire logic [63:0]   i_rxpb_dob,   // Rx buffer port B data
	output logic               o_rxpb_enb,   // Rx buffer port B select
	output logic               o_rxpb_web,   // Rx buffer B write enable
	output logic [7:0]         o_rxpb_addrb, // Rx buffer B word address
	output logic               o_txpb_ena,   // Tx buffer A select
	output logic               o_txpb_wea,   // Tx buffer A write enable
	output logic [7:0]         o_txpb_addra, // Tx buffer A word address
	output logic [63:0]        o_txpb_dia,   // Tx buffer A write data
	output logic               o_busy,       // Burst in progress
	output logic               o_err_irq     // Sticky bus error
);
	dmab_pkg::dmab_state_type st_ff;
	logic        is_wr_ff;
	logic [3:0]  beat_ff, len_ff;
	logic [31:0] addr_ff;
	logic [63:0] wdata_ff;
	logic        lane32;
	logic        wbeat;
	logic        rbeat;
	logic        dob_vld_ff;   // Receive buffer word lands this cycle
	logic        wd_ok_ff;     // Write data register holds a fresh word
	// ==========================================================
	// Constant attributes; only one ID and no locking
	assign lane32      = (i_bus_width == dmab_pkg::WID_32);
	assign axi.awid    = 4'h0; // R4
	assign axi.arid    = 4'h0; // R4
	assign axi.awlock  = 2'h0; // R4
	assign axi.arlock  = 2'h0; // R4
	assign axi.awburst = dmab_pkg::BURST_INCR; // R3
	assign axi.arburst = dmab_pkg::BURST_INCR; // R3
	assign axi.awcache = CACHE; // R8
	assign axi.arcache = CACHE; // R8
	assign axi.awprot  = PROT; // R8
	assign axi.arprot  = PROT; // R8
	// 128-bit is refused on this path, so it falls back to 64
	assign axi.awsize  = lane32 ? dmab_pkg::WID_32 : dmab_pkg::WID_64; // R2
	assign axi.arsize  = axi.awsize; // R2 R19
	assign axi.awlen   = {4'h0, len_ff}; // R1
	assign axi.arlen   = {4'h0, len_ff}; // R1
	assign axi.awaddr  = addr_ff;
	assign axi.araddr  = addr_ff;
	assign axi.awvalid = (st_ff == dmab_pkg::ST_ADDR) & is_wr_ff; // R20
	assign axi.arvalid = (st_ff == dmab_pkg::ST_ADDR) & ~is_wr_ff;
	// A beat is offered only once its word has reached wdata_ff
	assign axi.wvalid  = (st_ff == dmab_pkg::ST_DATA) & is_wr_ff
		& wd_ok_ff; // R20
	assign axi.wdata   = lane32 ? {32'h0, wdata_ff[31:0]} : wdata_ff; // R6
	assign axi.wlast   = axi.wvalid & (beat_ff == len_ff); // R7
	// Ready only while a burst is outstanding on that channel
	assign axi.bready  = (st_ff == dmab_pkg::ST_RESP); // R21
	assign axi.rready  = (st_ff == dmab_pkg::ST_DATA) & ~is_wr_ff; // R21
	assign wbeat = axi.wvalid & axi.wready;
	assign rbeat = axi.rvalid & axi.rready;
	// ==========================================================
	// Burst sequencer; reset asserts at once, release is the system's
	always_ff @(posedge axi.aclk or negedge axi.areset_n) begin // R9
		if (!axi.areset_n) begin
			st_ff    <= dmab_pkg::ST_IDLE;
			is_wr_ff <= 1'b0;
			beat_ff  <= 4'h0;
			len_ff   <= 4'h0;
			addr_ff  <= 32'h0;
		end else begin
			case (st_ff)
				dmab_pkg::ST_IDLE: begin
					beat_ff <= 4'h0;
					if (i_wr_start || i_rd_start) begin
						st_ff    <= dmab_pkg::ST_ADDR;
						is_wr_ff <= i_wr_start;
						len_ff   <= i_len; // R1
						addr_ff  <= i_addr;
					end
				end
				dmab_pkg::ST_ADDR: begin
					if ((axi.awvalid && axi.awready) ||
					    (axi.arvalid && axi.arready))
						st_ff <= dmab_pkg::ST_DATA; // R20
				end
				dmab_pkg::ST_DATA: begin
					if (wbeat || rbeat)
						beat_ff <= beat_ff + 4'h1;
					if (wbeat && axi.wlast)
						st_ff <= dmab_pkg::ST_RESP;
					if (rbeat && axi.rlast)
						st_ff <= dmab_pkg::ST_IDLE;
				end
				dmab_pkg::ST_RESP: begin
					if (axi.bvalid)
						st_ff <= dmab_pkg::ST_IDLE;
				end
				default: st_ff <= dmab_pkg::ST_IDLE;
			endcase
		end
	end
	// ==========================================================
	// Write data comes from the receive buffer bus-side port (read only).
	// The buffer answers a cycle after its select, so each word is fetched
	// once and flagged; fetching per beat costs bandwidth but never sends
	// a stale word.
	always_ff @(posedge axi.aclk or negedge axi.areset_n) begin
		if (!axi.areset_n) begin
			o_rxpb_enb   <= 1'b0;
			o_rxpb_web   <= 1'b0;
			o_rxpb_addrb <= 8'h00;
			dob_vld_ff   <= 1'b0;
			wd_ok_ff     <= 1'b0;
			wdata_ff     <= 64'h0;
		end else begin
			o_rxpb_web   <= 1'b0; // R14
			// First word as the write is taken, the next after each beat but the last
			o_rxpb_enb   <= ((st_ff == dmab_pkg::ST_IDLE) & i_wr_start)
				| (wbeat & ~axi.wlast);
			// Beat count may still be stale in the first idle cycle
			if (st_ff == dmab_pkg::ST_IDLE)
				o_rxpb_addrb <= i_rx_pb_base; // R16
			else
				o_rxpb_addrb <= i_rx_pb_base + {4'h0, beat_ff}
					+ {7'h0, wbeat}; // R16
			dob_vld_ff   <= o_rxpb_enb;
			if (wbeat)
				wd_ok_ff <= 1'b0;
			// A landing word wins over the beat that frees the register
			if (dob_vld_ff) begin
				wd_ok_ff <= 1'b1;
				wdata_ff <= lane32 ? {32'h0, i_rxpb_dob[31:0]}
					: i_rxpb_dob; // R15
			end
		end
	end
	// ==========================================================
	// Read data lands in the transmit buffer bus-side port (write only)
	always_ff @(posedge axi.aclk or negedge axi.areset_n) begin
		if (!axi.areset_n) begin
			o_txpb_ena   <= 1'b0;
			o_txpb_wea   <= 1'b1;
			o_txpb_addra <= 8'h00;
			o_txpb_dia   <= 64'h0;
		end else begin
			o_txpb_wea   <= 1'b1; // R12
			o_txpb_ena   <= rbeat;
			o_txpb_addra <= i_tx_pb_base + {4'h0, beat_ff}; // R16
			// Upper read lanes are ignored whatever the system ties
			o_txpb_dia   <= lane32 ? {32'h0, axi.rdata[31:0]}
				: axi.rdata[63:0]; // R15 R10
		end
	end
	// ==========================================================
	// Sticky error; reset only clears it
	always_ff @(posedge axi.aclk or negedge axi.areset_n) begin
		if (!axi.areset_n) begin
			o_err_irq <= 1'b0;
			o_busy    <= 1'b0;
		end else begin
			o_busy <= (st_ff != dmab_pkg::ST_IDLE);
			if ((axi.bvalid && axi.bready &&
			     axi.bresp != dmab_pkg::RESP_OKAY) ||
			    (rbeat && axi.rresp != dmab_pkg::RESP_OKAY))
				o_err_irq <= 1'b1; // R5
		end
	end
endmodule : dmab_dma_master

// ### design/dmab_pkg.sv
// Package: shared constants and types for the DMA boundary ends
package dmab_pkg;
	// ==========================================================
	// Bus widths
	localparam int ADDR_W       = 32;
	localparam int WDATA_W      = 64;
	localparam int RDATA_W      = 128;
	localparam int PB_DATA_W    = 64;
	localparam int PB_ADDR_W    = 8;   // Sets packet buffer depth
	localparam int ID_W         = 4;
	// ==========================================================
	// Burst attributes
	localparam logic [7:0] LEN_MAX    = 8'h0F;
	localparam logic [1:0] BURST_INCR = 2'h1;
	localparam logic [1:0] RESP_OKAY  = 2'h0;
	localparam logic [3:0] CACHE_VAL  = 4'h3;
	localparam logic [2:0] PROT_VAL   = 3'h0;
	// ==========================================================
	// Data path width selection
	localparam logic [2:0] WID_32  = 3'h2;
	localparam logic [2:0] WID_64  = 3'h3;
	localparam logic [2:0] WID_128 = 3'h4;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ADDR = 2'b01,
		ST_DATA = 2'b10,
		ST_RESP = 2'b11
	} dmab_state_type;
endpackage : dmab_pkg

// ### design/dmab_axi_if.sv
// Interface: AXI4 master port joining the DMA end and the memory end
interface dmab_axi_if (
	input wire logic aclk,       // Bus clock
	input wire logic areset_n    // Active-low bus reset
);
	logic [31:0] awaddr;
	logic [7:0]  awlen;
	logic [2:0]  awsize;
	logic [1:0]  awburst;
	logic        awvalid;
	logic        awready;
	logic [3:0]  awid;
	logic [3:0]  awcache;
	logic [1:0]  awlock;
	logic [2:0]  awprot;
	logic [63:0] wdata;
	logic        wlast;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic [3:0]  bid;
	logic        bvalid;
	logic        bready;
	logic [31:0] araddr;
	logic [7:0]  arlen;
	logic [2:0]  arsize;
	logic [1:0]  arburst;
	logic        arvalid;
	logic        arready;
	logic [3:0]  arid;
	logic [3:0]  arcache;
	logic [1:0]  arlock;
	logic [2:0]  arprot;
	logic [127:0] rdata;
	logic        rlast;
	logic [1:0]  rresp;
	logic [3:0]  rid;
	logic        rvalid;
	logic        rready;
	modport master (
		input  aclk, areset_n, awready, wready, bresp, bid, bvalid,
		arready, rdata, rlast, rresp, rid, rvalid,
		output awaddr, awlen, awsize, awburst, awvalid, awid, awcache,
		awlock, awprot, wdata, wlast, wvalid, bready, araddr, arlen,
		arsize, arburst, arvalid, arid, arcache, arlock, arprot, rready
	);
	modport slave (
		input  aclk, areset_n, awaddr, awlen, awsize, awburst, awvalid,
		awid, awcache, awlock, awprot, wdata, wlast, wvalid, bready,
		araddr, arlen, arsize, arburst, arvalid, arid, arcache, arlock,
		arprot, rready,
		output awready, wready, bresp, bid, bvalid, arready, rdata,
		rlast, rresp, rid, rvalid
	);
endinterface : dmab_axi_if

// ### design/dmab_mem_slave.sv
// Memory end: AXI4 slave with a 16-word memory, on the bus clock
// [R9] [R10] [R20] kept here; reset release is the system's.
module dmab_mem_slave (
	dmab_axi_if.slave   axi,            // AXI slave side
	input  wire logic   i_err_inject,   // Answer bursts with SLVERR until a write response ends with this low
	output logic        o_busy          // Burst in progress
);
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int       MEM_D = 16;
	logic [63:0] mem_ff [MEM_D];
	logic [3:0]  wptr_ff, rptr_ff;
	logic [7:0]  rcnt_ff;
	logic        err_ff, aw_ok_ff, ar_ok_ff, bv_ff, rv_ff;
	logic [1:0]  resp_ff;
	// ==========================================================
	// Fixed handshake answers
	assign axi.awready = ~aw_ok_ff & ~bv_ff;
	assign axi.wready  = aw_ok_ff;
	assign axi.arready = ~ar_ok_ff;
	assign axi.bvalid  = bv_ff;
	assign axi.rvalid  = rv_ff;
	assign axi.bresp   = resp_ff;
	assign axi.rresp   = resp_ff;
	assign axi.bid     = 4'h0;
	assign axi.rid     = 4'h0;
	assign axi.rlast   = rv_ff & (rcnt_ff == 8'h00);
	// Upper read lanes tied low since the path is 64 bits
	assign axi.rdata   = {64'h0, mem_ff[rptr_ff]}; // R10
	assign o_busy      = aw_ok_ff | ar_ok_ff | bv_ff;
	// ==========================================================
	// Write channel and response
	always_ff @(posedge axi.aclk or negedge axi.areset_n) begin // R9
		if (!axi.areset_n) begin
			aw_ok_ff <= 1'b0;
			bv_ff    <= 1'b0;
			wptr_ff  <= 4'h0;
			err_ff   <= 1'b0;
		end else begin
			if (i_err_inject)
				err_ff <= 1'b1;
			if (axi.awvalid && axi.awready) begin // R20
				aw_ok_ff <= 1'b1;
				wptr_ff  <= axi.awaddr[6:3];
			end
			if (axi.wvalid && axi.wready) begin
				wptr_ff <= wptr_ff + 4'h1;
				if (axi.wlast) begin
					aw_ok_ff <= 1'b0;
					bv_ff    <= 1'b1;
				end
			end
			if (bv_ff && axi.bready) begin
				bv_ff  <= 1'b0;
				err_ff <= i_err_inject;
			end
		end
	end
	// Storage has no reset, so it sits in a process of its own
	always_ff @(posedge axi.aclk) begin
		if (axi.wvalid && axi.wready)
			mem_ff[wptr_ff] <= axi.wdata;
	end
	// ==========================================================
	// Read channel
	always_ff @(posedge axi.aclk or negedge axi.areset_n) begin
		if (!axi.areset_n) begin
			ar_ok_ff <= 1'b0;
			rv_ff    <= 1'b0;
			rptr_ff  <= 4'h0;
			rcnt_ff  <= 8'h00;
		end else if (axi.arvalid && axi.arready) begin // R20
			ar_ok_ff <= 1'b1;
			rv_ff    <= 1'b1;
			rptr_ff  <= axi.araddr[6:3];
			rcnt_ff  <= axi.arlen;
		end else if (rv_ff && axi.rready) begin
			rptr_ff <= rptr_ff + 4'h1;
			rcnt_ff <= rcnt_ff - 8'h01;
			if (rcnt_ff == 8'h00) begin
				rv_ff    <= 1'b0;
				ar_ok_ff <= 1'b0;
			end
		end
	end
	// Response code shared by both channels
	always_ff @(posedge axi.aclk or negedge axi.areset_n) begin
		if (!axi.areset_n)
			resp_ff <= 2'h0;
		else
			resp_ff <= err_ff ? RESP_SLVERR : 2'h0;
	end
endmodule : dmab_mem_slave

// ### sim/dmab_props.sv
// Checker: AXI master rules watched on the joining interface
module dmab_props (
	input wire logic       aclk,     // Bus clock
	input wire logic       areset_n, // Bus reset, low
	input wire logic [7:0] awlen,    // AW length
	input wire logic [7:0] arlen,    // AR length
	input wire logic [1:0] awburst,  // AW burst
	input wire logic [1:0] arburst,  // AR burst
	input wire logic [3:0] awid,     // AW id
	input wire logic [3:0] arid,     // AR id
	input wire logic       awvalid,  // AW valid
	input wire logic       awready,  // AW ready
	input wire logic [31:0] awaddr,  // AW address
	input wire logic       arvalid,  // AR valid
	input wire logic       wvalid,   // W valid
	input wire logic       wready,   // W ready
	input wire logic       wlast,    // W last
	input wire logic [63:0] wdata,   // W data
	input wire logic       bvalid,   // B valid
	input wire logic       bready,   // B ready
	input wire logic       rvalid,   // R valid
	input wire logic       rready,   // R ready
	input wire logic       rlast     // R last
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!areset_n);
	logic [7:0] len_ff;
	logic [7:0] beat_ff;
	// ==========================================================
	// Beat count, so wlast is tied to the granted length
	always_ff @(posedge aclk or negedge areset_n) begin
		if (!areset_n)
			len_ff <= 8'h00;
		else if (awvalid && awready)
			len_ff <= awlen;
	end
	// Restarts on wlast; a missing wlast shows as a length mismatch
	always_ff @(posedge aclk or negedge areset_n) begin
		if (!areset_n)
			beat_ff <= 8'h00;
		else if (wvalid && wready)
			beat_ff <= wlast ? 8'h00 : beat_ff + 8'h01;
	end
	// ==========================================================
	// Assertions
	a_awlen_bound: assert property (awvalid |-> awlen[7:4] == 4'h0)
		else $error("write length above sixteen beats");
	a_arlen_bound: assert property (arvalid |-> arlen[7:4] == 4'h0)
		else $error("read length above sixteen beats");
	a_burst_incr: assert property (awvalid || arvalid |->
		awburst == 2'h1 && arburst == 2'h1)
		else $error("burst type not incrementing");
	a_id_low: assert property (awid == 4'h0 && arid == 4'h0)
		else $error("transaction id not zero");
	a_aw_held: assert property (awvalid && !awready |=>
		awvalid && $stable(awaddr) && $stable(awlen))
		else $error("write address dropped before ready");
	a_w_held: assert property (wvalid && !wready |=>
		wvalid && $stable(wdata) && $stable(wlast))
		else $error("write data dropped before ready");
	a_wlast_beat: assert property (wvalid && wready |->
		wlast == (beat_ff == len_ff))
		else $error("write last not on final beat");
	a_bready_held: assert property (bready && !bvalid |=> bready)
		else $error("response ready dropped while waiting");
	a_rready_held: assert property (rready && !(rvalid && rlast)
		|=> rready)
		else $error("read ready dropped inside burst");
	c_long_write: cover property (awvalid && awready && awlen == 8'h0F);
	c_read_done: cover property (rvalid && rready && rlast);
	c_write_done: cover property (bvalid && bready);
endmodule : dmab_props

// ### sim/dmab_test.sv
// Testbench: DMA master and memory slave joined on one AXI port
module dmab_test;
	timeunit 1ns;
	timeprecision 1ns;
`define CHK(nm, got, ex) begin checks++; if ((got) !== (ex)) begin \
	miscompares++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
	logic        clk, rst, wr, rd, err_inj, exp_irq;
	logic        enb, web, ena, wea, mbusy, irq, sbusy;
	logic [2:0]  width, siz;
	logic [3:0]  len;
	logic [7:0]  rxb, txb, addrb, addra;
	logic [31:0] addr;
	logic [63:0] dob, dia, msk, d;
	logic [63:0] wq[$], rq[$];
	logic [63:0] mdl[16];   // Memory model, one 64-bit word per entry
	logic [2:0]  tbl[3] = '{dmab_pkg::WID_32, dmab_pkg::WID_64,
		dmab_pkg::WID_128};
	int          checks, miscompares, nh, nw, nt;
	dmab_axi_if axi_inst (.aclk(clk), .areset_n(!rst));
	dmab_dma_master dmab_dma_master_inst (.axi(axi_inst.master),
		.i_bus_width(width), .i_wr_start(wr), .i_rd_start(rd),
		.i_addr(addr), .i_len(len), .i_rx_pb_base(rxb),
		.i_tx_pb_base(txb), .i_rxpb_dob(dob), .o_rxpb_enb(enb),
		.o_rxpb_web(web), .o_rxpb_addrb(addrb), .o_txpb_ena(ena),
		.o_txpb_wea(wea), .o_txpb_addra(addra), .o_txpb_dia(dia),
		.o_busy(mbusy), .o_err_irq(irq));
	dmab_mem_slave dmab_mem_slave_inst (.axi(axi_inst.slave),
		.i_err_inject(err_inj), .o_busy(sbusy));
	dmab_props dmab_props_inst (.aclk(clk), .areset_n(axi_inst.areset_n),
		.awlen(axi_inst.awlen), .arlen(axi_inst.arlen),
		.awburst(axi_inst.awburst), .arburst(axi_inst.arburst),
		.awid(axi_inst.awid), .arid(axi_inst.arid),
		.awvalid(axi_inst.awvalid), .awready(axi_inst.awready),
		.awaddr(axi_inst.awaddr), .arvalid(axi_inst.arvalid),
		.wvalid(axi_inst.wvalid), .wready(axi_inst.wready),
		.wlast(axi_inst.wlast), .wdata(axi_inst.wdata),
		.bvalid(axi_inst.bvalid), .bready(axi_inst.bready),
		.rvalid(axi_inst.rvalid), .rready(axi_inst.rready),
		.rlast(axi_inst.rlast));
	// ==========================================================
	// Rx buffer contents, a pattern of the word address
	function automatic logic [63:0] pat(input logic [7:0] a);
		return {8{a}} ^ 64'hF0E1_D2C3_B4A5_9687;
	endfunction : pat
	task automatic close_out();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : close_out
	// One burst; the start stays up a second cycle, which must be ignored
	task automatic burst(input logic w, input logic e, input logic [3:0] l,
		input int k);
		int n;
		@(negedge clk);
		width = tbl[k % 3];
		msk = (width === dmab_pkg::WID_32) ? 64'hFFFF_FFFF : '1;
		siz = (width === dmab_pkg::WID_32) ? 3'h2 : 3'h3;
		addr = $urandom & 32'hFFFF_FF00;
		len = l;
		rxb = 8'($urandom);
		txb = 8'($urandom);
		err_inj = e;
		{nh, nw, nt} = '0;
		wq.delete();
		rq.delete();
		// Expected words come from the buffer pattern and the memory model
		if (w)
			for (int i = 0; i <= l; i++) begin
				wq.push_back(pat(8'(rxb + i)) & msk);
				mdl[4'(addr[6:3] + i)] = pat(8'(rxb + i)) & msk;
			end
		else
			for (int i = 0; i <= l; i++)
				rq.push_back(mdl[4'(addr[6:3] + i)] & msk);
		wr = w;
		rd = 1'b1;
		repeat (2) @(negedge clk);
		wr = 1'b0;
		rd = 1'b0;
		n = 0;
		while (mbusy && n < 300) begin
			@(negedge clk);
			n++;
		end
		if (n >= 300) begin
			miscompares++;
			close_out();
		end
		@(negedge clk);
		exp_irq |= e;
		`CHK("bursts", nh, 1)
		`CHK("beats", w ? wq.size() : nt, w ? 0 : l + 1)
		`CHK("irq", irq, exp_irq)
		err_inj = 1'b0;
		$display("burst %0d done", k);
	endtask : burst
	// ==========================================================
	// Buffer model and result monitor, sampled before the edge lands
	always @(posedge clk) begin
		if (enb) begin
			dob <= pat(addrb);
			`CHK("rx addr", addrb, 8'(rxb + nw))
			`CHK("rx we", web, 1'b0)
			nw++;
		end
		if (ena) begin
			d = rq.pop_front();
			`CHK("tx addr", addra, 8'(txb + nt))
			`CHK("tx we", wea, 1'b1)
			`CHK("tx data", dia & msk, d)
			nt++;
		end
		if (axi_inst.awvalid && axi_inst.awready) begin
			nh++;
			`CHK("awaddr", axi_inst.awaddr, addr)
			`CHK("awlen", axi_inst.awlen, {4'h0, len})
			`CHK("awsize", axi_inst.awsize, siz)
			`CHK("attr", {axi_inst.awcache, axi_inst.arprot},
				{dmab_pkg::CACHE_VAL, dmab_pkg::PROT_VAL})
			`CHK("lock", {axi_inst.awlock, axi_inst.arlock}, 4'h0)
		end
		if (axi_inst.arvalid && axi_inst.arready) begin
			nh++;
			`CHK("araddr", axi_inst.araddr, addr)
			`CHK("arlen", axi_inst.arlen, {4'h0, len})
			`CHK("arsize", axi_inst.arsize, siz)
		end
		if (axi_inst.wvalid && axi_inst.wready) begin
			d = wq.pop_front();
			`CHK("wdata", axi_inst.wdata, d)
			`CHK("wlast", axi_inst.wlast, wq.size() == 0)
		end
		if (axi_inst.rvalid && axi_inst.rready)
			`CHK("rdata hi", axi_inst.rdata[127:64], 64'h0)
	end
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	// Main sequence: all widths, longest and shortest bursts, errors
	initial begin
		{rst, wr, rd, err_inj, exp_irq, checks, miscompares} = '1;
		{wr, rd, err_inj, exp_irq, checks, miscompares} = '0;
		{width, len, rxb, txb, addr, dob, msk} = '0;
		void'($urandom(32'h5FDA141C));
		repeat (2) @(negedge clk);
		rst = 1'b0;
		for (int k = 0; k < 12; k++)
			burst(~k[0], 1'b0, k < 2 ? 4'hF : k < 4 ? 4'h0 : 4'($urandom), k);
		burst(1'b1, 1'b1, 4'h3, 12);
		// A reset in mid-run is the only way to clear the sticky error
		rst = 1'b1;
		repeat (2) @(negedge clk);
		rst = 1'b0;
		exp_irq = 1'b0;
		`CHK("irq reset", irq, 1'b0)
		burst(1'b0, 1'b1, 4'h2, 13);
		close_out();
	end
endmodule : dmab_test
